/* hdl/ebsc_pkg.sv */
// shared constants and types for the external bus show-cycle controller
package ebsc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] ADDR_CTRL       = 32'h0000_0000;
  localparam logic [31:0] ADDR_STAT       = 32'h0000_0004;
  localparam int          CTRL_SHOW_LO    = 0;   // show_cycle_ctl_lo
  localparam int          CTRL_SHOW_HI    = 1;   // show_cycle_ctl_hi
  localparam int          CTRL_SUPER      = 2;   // supervisor_space_only
  localparam int          CTRL_SYNC       = 3;   // synchronous input mode
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  localparam int          STAT_STATE_LSB  = 0;
  localparam int          STAT_GRANT      = 3;
  localparam int          STAT_SLAVE      = 4;
  localparam int          STAT_BUSERR     = 5;
  localparam int          STAT_SHOW_LSB   = 6;

  // ****************************************
  // bus encodings
  // ****************************************
  localparam logic [1:0]  SHOW_NORMAL     = 2'h0;
  localparam logic [1:0]  SHOW_NO_ARB     = 2'h1;
  localparam logic [3:0]  FC_SUPER_DATA   = 4'h5;
  localparam logic [1:0]  ACK_N_32        = 2'h0;
  localparam logic [1:0]  ACK_N_16        = 2'h1;
  localparam logic [1:0]  ACK_N_8         = 2'h2;
  localparam logic [1:0]  ACK_N_NONE      = 2'h3;
  localparam logic [1:0]  PORT_8          = 2'h1;
  localparam logic [1:0]  PORT_16         = 2'h2;
  localparam logic [1:0]  PORT_32         = 2'h0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam int          SYNC_STAGES     = 2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_END   = 3'b011,
    ST_GRANT = 3'b100
  } ebsc_state_t;

endpackage

/* hdl/ebsc_pin_sampler.sv */
// two-flop sampler for the pin inputs of the bus controller
`timescale 1ns/1ns
`default_nettype none
module ebsc_pin_sampler #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_pins,
  input  wire logic [WIDTH-1:0] i_rst_val,
  output logic      [WIDTH-1:0] o_pins
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] hold_q;

  // ****************************************
  // capture and resolve
  // ****************************************
  // first stage catches the level, second stage settles it to 0 or 1
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= i_rst_val;
      hold_q <= i_rst_val;
    end else begin
      meta_q <= i_pins;
      hold_q <= meta_q;
    end
  end

  assign o_pins = hold_q;

endmodule
`default_nettype wire

/* hdl/ebsc_bus_ctrl.sv */
// external bus master controller with show-cycle and arbitration control
// Contract
// - the bus serves 8, 16 and 32 bit ports and all of them follow the termination handshake.
// - in asynchronous mode inputs pass a synchronizer, adding delay before their level is used.
// - in synchronous mode an acknowledged bus cycle completes in three clocks.
// - a fast-termination access is ended internally and completes in two clocks.
// - every input is caught in a sample window and used at the level the sampler resolved, stable or not.
// - an input that moved in the window is still resolved to a definite level before use.
// - show field 00 gives split-bus operation, no show cycles and external arbitration on.
// - show field 01 shows internal cycles, disables arbitration and never asserts bus grant.
// - show field 1x shows internal cycles, keeps arbitration and halts internal work while granted.
// - in normal master operation internal cycles do not appear as external acknowledge cycles.
// - fast-termination cycles never drive data-size acknowledge outside, in any show setting.
// - in slave mode the show field reads 00 and software writes to it have no effect.
// - with show cycles off and the bus free, an internal access drives its address and code out.
// - with supervisor-only set, global accesses need code 5; a user write is dropped with error.
`timescale 1ns/1ns
`default_nettype none
module ebsc_bus_ctrl (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // register bus
  input  wire logic        i_awvalid,
  input  wire logic [31:0] i_awaddr,
  output logic             o_awready,
  input  wire logic        i_wvalid,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_wready,
  output logic             o_bvalid,
  output logic [1:0]       o_bresp,
  input  wire logic        i_bready,
  input  wire logic        i_arvalid,
  input  wire logic [31:0] i_araddr,
  output logic             o_arready,
  output logic             o_rvalid,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_rready,
  // internal access requests
  input  wire logic        i_req_valid,
  input  wire logic        i_req_write,
  input  wire logic        i_req_internal,
  input  wire logic        i_req_fast,
  input  wire logic        i_req_global,
  input  wire logic [31:0] i_req_addr,
  input  wire logic [31:0] i_req_wdata,
  input  wire logic [3:0]  i_req_fc,
  input  wire logic [31:0] i_int_rdata,
  output logic             o_req_done,
  output logic             o_req_buserr,
  output logic [31:0]      o_req_rdata,
  output logic [1:0]       o_req_port_size,
  // external bus pins
  output logic [31:0]      o_addr,
  output logic [3:0]       o_function_code,
  output logic             o_as_n,
  output logic             o_rw,
  output logic             o_ctl_oe,
  output logic [31:0]      o_data,
  output logic             o_data_oe,
  input  wire logic [31:0] i_data,
  input  wire logic [1:0]  i_data_size_ack_n,
  output logic [1:0]       o_data_size_ack_n,
  output logic             o_data_size_ack_oe,
  input  wire logic        i_bus_error_n,
  input  wire logic        i_bus_request_n,
  output logic             o_bus_grant_n,
  input  wire logic        i_slave_mode
);

  // ****************************************
  // pin sampling
  // ****************************************
  localparam int PW = 37;
  logic [PW-1:0] smp;
  logic [PW-1:0] res_q;
  logic [PW-1:0] used;
  logic [3:0]    ctrl_q;
  ebsc_pin_sampler #(.WIDTH(PW)) u_smp (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_pins    ({i_data, i_data_size_ack_n, i_bus_error_n, i_bus_request_n, i_slave_mode}),
    .i_rst_val ({32'h0000_0000, 5'h1e}),
    .o_pins    (smp)
  );

  // asynchronous mode adds one more resolve stage before levels are used
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) res_q <= {32'h0000_0000, 5'h1e};
    else          res_q <= smp;
  end
  assign used = ctrl_q[ebsc_pkg::CTRL_SYNC] ? smp : res_q;

  wire [31:0] pin_data   = used[36:5];
  wire [1:0]  pin_ack_n  = used[4:3];
  wire        pin_buserr_n = used[2];
  wire        pin_req_n    = used[1];
  wire        slave      = used[0];

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [1:0] ack_to_port(input logic [1:0] ack_n);
    case (ack_n)
      ebsc_pkg::ACK_N_16: ack_to_port = ebsc_pkg::PORT_16;
      ebsc_pkg::ACK_N_8:  ack_to_port = ebsc_pkg::PORT_8;
      default:            ack_to_port = ebsc_pkg::PORT_32;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a == ebsc_pkg::ADDR_CTRL) || (a == ebsc_pkg::ADDR_STAT);
  endfunction

  // ****************************************
  // mode decode
  // ****************************************
  ebsc_pkg::ebsc_state_t state_q;
  ebsc_pkg::ebsc_state_t state_d;
  logic        internal_q;
  logic        fast_q;
  logic        write_q;
  logic        last_buserr_q;

  // slave mode forces the field to normal regardless of what software holds
  wire [1:0] show_eff = slave ? ebsc_pkg::SHOW_NORMAL : ctrl_q[1:0];
  wire       show_on  = (show_eff != ebsc_pkg::SHOW_NORMAL);
  wire       arb_en   = (show_eff != ebsc_pkg::SHOW_NO_ARB);
  wire       super_only = ctrl_q[ebsc_pkg::CTRL_SUPER];
  wire       deny     = i_req_global && super_only && (i_req_fc != ebsc_pkg::FC_SUPER_DATA);
  wire       idle     = (state_q == ebsc_pkg::ST_IDLE);
  wire       grant_go = idle && !pin_req_n && arb_en;
  wire       take     = idle && i_req_valid && !grant_go;
  // split-bus mode lets internal accesses finish while an outside master owns the bus;
  // in 1x nothing is taken in the grant state, which halts internal activity
  wire       int_in_grant = (state_q == ebsc_pkg::ST_GRANT) && i_req_valid && i_req_internal
                            && !show_on && !deny;
  wire       term     = (pin_ack_n != ebsc_pkg::ACK_N_NONE) || !pin_buserr_n;
  wire       to_end   = (state_d == ebsc_pkg::ST_END) && (state_q != ebsc_pkg::ST_END);

  // ****************************************
  // cycle state machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ebsc_pkg::ST_IDLE: begin
        if (grant_go) state_d = ebsc_pkg::ST_GRANT;
        else if (take && (deny || (i_req_internal && !show_on))) state_d = ebsc_pkg::ST_END;
        else if (take) state_d = ebsc_pkg::ST_ADDR;
      end
      ebsc_pkg::ST_ADDR: begin
        if (fast_q) state_d = ebsc_pkg::ST_END;
        else        state_d = ebsc_pkg::ST_WAIT;
      end
      ebsc_pkg::ST_WAIT: begin
        if (internal_q || term) state_d = ebsc_pkg::ST_END;
      end
      ebsc_pkg::ST_END: begin
        state_d = ebsc_pkg::ST_IDLE;
      end
      ebsc_pkg::ST_GRANT: begin
        if (pin_req_n || !arb_en) state_d = ebsc_pkg::ST_IDLE;
      end
      default: begin
        state_d = ebsc_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // pin drive decode
  // ****************************************
  wire        strobe_d  = (state_d == ebsc_pkg::ST_ADDR) || (state_d == ebsc_pkg::ST_WAIT);
  wire [31:0] addr_d    = take ? i_req_addr : o_addr;
  wire [3:0]  fc_d      = take ? i_req_fc : o_function_code;
  wire        wr_d      = take ? i_req_write : write_q;
  wire        intl_d    = take ? i_req_internal : internal_q;
  wire        fast_d    = take ? i_req_fast : fast_q;
  // internal cycles show their own acknowledge only when shown and not fast
  wire        ack_oe_d  = (state_d == ebsc_pkg::ST_WAIT) && intl_d && !fast_d;
  wire        data_oe_d = strobe_d && (wr_d || intl_d);
  wire        buserr_d  = (take && deny) || (state_q == ebsc_pkg::ST_WAIT && !internal_q
                          && !pin_buserr_n);
  // intl_d, not internal_q: a cycle that ends in its taking clock has not stored its kind yet
  wire [1:0]  port_d    = intl_d ? ebsc_pkg::PORT_32 : ack_to_port(pin_ack_n);
  wire [31:0] rdata_d   = (intl_d || int_in_grant) ? i_int_rdata : pin_data;

  // ****************************************
  // cycle registers
  // ****************************************
  // a denied access only reports the error; its pins never strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q            <= ebsc_pkg::ST_IDLE;
      internal_q         <= 1'b0;
      fast_q             <= 1'b0;
      write_q            <= 1'b0;
      o_addr             <= 32'h0000_0000;
      o_function_code    <= 4'h0;
      o_rw               <= 1'b1;
      o_as_n             <= 1'b1;
      o_ctl_oe           <= 1'b1;
      o_data             <= 32'h0000_0000;
      o_data_oe          <= 1'b0;
      o_data_size_ack_n  <= ebsc_pkg::ACK_N_NONE;
      o_data_size_ack_oe <= 1'b0;
      o_bus_grant_n      <= 1'b1;
    end else begin
      state_q            <= state_d;
      internal_q         <= intl_d;
      fast_q             <= fast_d;
      write_q            <= wr_d;
      o_addr             <= addr_d;
      o_function_code    <= fc_d;
      o_rw               <= !wr_d;
      o_as_n             <= !strobe_d;
      o_ctl_oe           <= (state_d != ebsc_pkg::ST_GRANT);
      o_data             <= take ? (i_req_write ? i_req_wdata : i_int_rdata) : o_data;
      o_data_oe          <= data_oe_d;
      o_data_size_ack_n  <= ack_oe_d ? ebsc_pkg::ACK_N_32 : ebsc_pkg::ACK_N_NONE;
      o_data_size_ack_oe <= ack_oe_d;
      o_bus_grant_n      <= (state_d != ebsc_pkg::ST_GRANT);
    end
  end

  // completion report toward the internal requester
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_req_done      <= 1'b0;
      o_req_buserr    <= 1'b0;
      o_req_rdata     <= 32'h0000_0000;
      o_req_port_size <= ebsc_pkg::PORT_32;
      last_buserr_q   <= 1'b0;
    end else begin
      o_req_done      <= to_end || int_in_grant;
      o_req_buserr    <= (to_end || int_in_grant) && buserr_d;
      o_req_rdata     <= (to_end || int_in_grant) ? rdata_d : o_req_rdata;
      o_req_port_size <= to_end ? port_d : o_req_port_size;
      last_buserr_q   <= to_end ? buserr_d : last_buserr_q;
    end
  end

  // ****************************************
  // register bus slave
  // ****************************************
  logic        aw_have_q;
  logic        w_have_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  wire         aw_hs    = i_awvalid && o_awready;
  wire         w_hs     = i_wvalid && o_wready;
  wire         do_write = aw_have_q && w_have_q && !o_bvalid;
  wire         ctrl_hit = do_write && (awaddr_q == ebsc_pkg::ADDR_CTRL) && wstrb0_q;
  // the show field is frozen while strapped as a slave
  wire [1:0]   show_new = slave ? ctrl_q[1:0] : wdata_q[1:0];
  wire [31:0]  stat_val = {24'h00_0000, show_eff, last_buserr_q, slave,
                           (state_q == ebsc_pkg::ST_GRANT), state_q};
  wire [31:0]  ctrl_val = {28'h000_0000, ctrl_q[3:2], show_eff};
  wire [31:0]  rd_val   = (i_araddr == ebsc_pkg::ADDR_CTRL) ? ctrl_val : stat_val;

  // write address and data are accepted in either order, response after both
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      wstrb0_q  <= 1'b0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= ebsc_pkg::RESP_OKAY;
      ctrl_q    <= ebsc_pkg::CTRL_RESET;
    end else begin
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb0_q <= i_wstrb[0];
        o_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= is_mapped(awaddr_q) ? ebsc_pkg::RESP_OKAY : ebsc_pkg::RESP_SLVERR;
      end
      if (ctrl_hit) ctrl_q <= {wdata_q[3:2], show_new};
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= ebsc_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= is_mapped(i_araddr) ? rd_val : 32'h0000_0000;
      o_rresp   <= is_mapped(i_araddr) ? ebsc_pkg::RESP_OKAY : ebsc_pkg::RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_no_grant_01: assert property ((show_eff == ebsc_pkg::SHOW_NO_ARB) && $past(show_eff ==
    ebsc_pkg::SHOW_NO_ARB) |-> o_bus_grant_n) else $error("grant asserted with arbitration off");
  a_fast_two_clk: assert property ((state_q == ebsc_pkg::ST_ADDR) && fast_q
    |=> (state_q == ebsc_pkg::ST_END) ##1 (state_q == ebsc_pkg::ST_IDLE))
    else $error("fast cycle not two clocks");
  a_sync_three_clk: assert property ((state_q == ebsc_pkg::ST_ADDR) && !fast_q
    ##1 (state_q == ebsc_pkg::ST_WAIT) && (term || internal_q)
    |=> (state_q == ebsc_pkg::ST_END) && o_req_done)
    else $error("acknowledged cycle did not end");
  a_fast_no_ack: assert property (fast_q && !idle |-> !o_data_size_ack_oe)
    else $error("acknowledge driven on fast cycle");
  a_normal_no_show: assert property (take && i_req_internal && !show_on
    |=> o_as_n && !o_data_size_ack_oe && o_req_done)
    else $error("internal cycle shown in normal mode");
  a_free_bus_addr: assert property (take && i_req_internal && !show_on
    |=> (o_addr == $past(i_req_addr)) && (o_function_code == $past(i_req_fc)) && o_ctl_oe)
    else $error("internal address not mirrored");
  a_super_deny: assert property (take && deny
    |=> o_as_n && o_req_done && o_req_buserr)
    else $error("user access to global space not refused");
  a_slave_field: assert property (slave && $past(slave)
    |-> (show_eff == ebsc_pkg::SHOW_NORMAL) && $stable(ctrl_q[1:0]))
    else $error("show field changed in slave mode");
  a_halt_in_grant: assert property ((state_q == ebsc_pkg::ST_GRANT) && show_on
    |-> !int_in_grant && !o_req_done) else $error("internal work during grant in 1x");
  a_async_delay: assert property (!ctrl_q[ebsc_pkg::CTRL_SYNC] |-> used == $past(smp))
    else $error("asynchronous input not delayed");
  a_hold_open: assert property ((state_q == ebsc_pkg::ST_WAIT) && !internal_q && !term
    |=> (state_q == ebsc_pkg::ST_WAIT) && !o_as_n) else $error("cycle closed early");

  c_ext_cycle: cover property ((state_q == ebsc_pkg::ST_WAIT) && !internal_q && term);
  c_show_cycle: cover property (o_data_size_ack_oe);
  c_grant: cover property (!o_bus_grant_n ##1 int_in_grant);
  c_port8: cover property (o_req_done && (o_req_port_size == ebsc_pkg::PORT_8));

endmodule
`default_nettype wire

/* tb/ebsc_ext_mem.sv */
// behavioural external memory that answers strobed cycles on the pins
`timescale 1ns/1ns
`default_nettype none
module ebsc_ext_mem (
  input  wire logic        i_clk,
  input  wire logic        i_as_n,
  input  wire logic [31:0] i_addr,
  input  wire logic [1:0]  i_ack_code,
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_err,
  output var logic [31:0]  o_data,
  output var logic [1:0]   o_ack_n,
  output var logic         o_bus_error_n
);
  logic [3:0] cnt_q;
  // ****************************************
  // termination
  // ****************************************
  // pins idle before the first edge
  initial begin
    o_data = 32'h0;
    o_ack_n = 2'h3;
    o_bus_error_n = 1'b1;
    cnt_q = 4'h0;
  end
  // it only answers and never opens a cycle of its own
  always @(posedge i_clk) begin
    if (i_as_n) begin
      cnt_q <= 4'h0;
      o_ack_n <= 2'h3;
      o_bus_error_n <= 1'b1;
      o_data <= ~o_data; // released bus must not show the stale word
    end else if (cnt_q < i_delay) begin
      cnt_q <= cnt_q + 4'h1; // slow device keeps the cycle open
    end else begin
      o_data <= i_addr ^ 32'h5a5a_0f0f;
      o_ack_n <= i_err ? 2'h3 : i_ack_code; // port width given by termination
      o_bus_error_n <= !i_err;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the external bus show-cycle controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ****************************************
  // signals and model state
  // ****************************************
  logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic        rv = 0, rw = 0, rin = 0, rf = 0, rg = 0, brq_n = 1, slv = 0, err = 0;
  logic [31:0] awa = 0, wd = 0, ara = 0, ra = 0, rwd = 0, ird = 0, q_rd;
  logic [3:0]  fc = 4'h1, dly = 4'h0;
  logic [1:0]  ack = 2'h0, rsp, mack_n, dack, ps, bres, rr;
  logic        awr, wr, bv, arr, rdv, dn, be, lbe, as_n, ack_oe, gnt_n, mberr_n, doe, rdw, coe;
  logic        saw_as = 0, saw_ack = 0, saw_gnt = 0;
  logic [3:0]  fco;
  logic [31:0] rd, adr, dout, mdata, rq_rd;
  logic [31:0] exp_q[$];
  logic [1:0]  codes[3] = '{ebsc_pkg::ACK_N_32, ebsc_pkg::ACK_N_16, ebsc_pkg::ACK_N_8};
  logic [1:0]  ports[3] = '{ebsc_pkg::PORT_32, ebsc_pkg::PORT_16, ebsc_pkg::PORT_8};
  int          bad_count = 0, cmp_count = 0, seed = 89430, lat, lat0, i;

  ebsc_bus_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_awvalid(awv), .i_awaddr(awa),
    .o_awready(awr), .i_wvalid(wv), .i_wdata(wd), .i_wstrb(4'hf), .o_wready(wr),
    .o_bvalid(bv), .o_bresp(bres), .i_bready(bre), .i_arvalid(arv), .i_araddr(ara),
    .o_arready(arr), .o_rvalid(rdv), .o_rdata(rd), .o_rresp(rr), .i_rready(rre),
    .i_req_valid(rv), .i_req_write(rw), .i_req_internal(rin), .i_req_fast(rf),
    .i_req_global(rg), .i_req_addr(ra), .i_req_wdata(rwd), .i_req_fc(fc),
    .i_int_rdata(ird), .o_req_done(dn), .o_req_buserr(be), .o_req_rdata(rq_rd),
    .o_req_port_size(ps), .o_addr(adr), .o_function_code(fco), .o_as_n(as_n), .o_rw(rdw),
    .o_ctl_oe(coe), .o_data(dout), .o_data_oe(doe), .i_data(doe ? dout : mdata),
    .i_data_size_ack_n(ack_oe ? dack : mack_n), .o_data_size_ack_n(dack),
    .o_data_size_ack_oe(ack_oe), .i_bus_error_n(mberr_n), .i_bus_request_n(brq_n),
    .o_bus_grant_n(gnt_n), .i_slave_mode(slv));
  ebsc_ext_mem mem (.i_clk(clk), .i_as_n(as_n), .i_addr(adr), .i_ack_code(ack),
    .i_delay(dly), .i_err(err), .o_data(mdata), .o_ack_n(mack_n), .o_bus_error_n(mberr_n));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // each channel is released at its own handshake edge
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= d;
    bre <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (!bv && n < 50);
    if (!bv) bad_count++;
    bre <= 0;
    rsp = bres;
  endtask
  task automatic axr(input logic [31:0] a);
    int n;
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rre <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 0;
    end while (!rdv && n < 50);
    if (!rdv) bad_count++;
    rre <= 0;
    q_rd = rd;
    rsp = rr;
  endtask
  // lat counts edges from the taking edge to the done pulse, plus one
  task automatic rq(input logic w, input logic inn, input logic f, input logic g,
                    input logic [3:0] c);
    logic [31:0] a, d;
    @(posedge clk);
    a = $random(seed);
    d = $random(seed);
    ra <= a;
    ird <= d;
    rwd <= $random(seed);
    rw <= w;
    rin <= inn;
    rf <= f;
    rg <= g;
    fc <= c;
    exp_q.push_back(inn ? d : a ^ 32'h5a5a_0f0f);
    rv <= 1;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (!dn && lat < 100);
    if (!dn) bad_count++;
    lbe = be;
    d = exp_q.pop_front();
    if (!w && !lbe) chk(rq_rd, d);
    // released at the next rising edge; the cycle has left idle, so it is not taken twice
    @(posedge clk);
    rv <= 0;
  endtask

  // ****************************************
  // clock, watchdog, monitor
  // ****************************************
  initial begin
    forever #5 clk = ~clk;
  end
  // the whole sequence needs about two hundred cycles
  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end
  always @(posedge clk) begin
    if (!as_n) saw_as <= 1;
    if (ack_oe) saw_ack <= 1;
    if (!gnt_n) saw_gnt <= 1;
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    axr(ebsc_pkg::ADDR_CTRL);
    chk(q_rd, 32'h0);
    axr(32'h0000_0100);
    chk(32'(rsp), 32'(ebsc_pkg::RESP_SLVERR));
    axw(32'h0000_0020, 32'h1);
    chk(32'(rsp), 32'(ebsc_pkg::RESP_SLVERR));
    axw(ebsc_pkg::ADDR_CTRL, 32'h8); // show field 00, the normal setting
    for (i = 0; i < 3; i++) begin
      ack <= codes[i];
      rq(0, 0, 0, 0, 4'h1);
      chk(32'(ps), 32'(ports[i]));
      if (i == 0) lat0 = lat;
    end
    ack <= ebsc_pkg::ACK_N_32;
    dly <= 4'h3;
    rq(0, 0, 0, 0, 4'h1);
    chk(32'(lat > lat0 + 2), 32'h1);
    dly <= 4'h0;
    err <= 1;
    rq(0, 0, 0, 0, 4'h1);
    chk(32'(lbe), 32'h1);
    err <= 0;
    saw_ack = 0;
    // a fast cycle is a write: read data cannot cross the pin sampler within two clocks
    rq(1, 0, 1, 0, 4'h1);
    chk(lat, 3);
    chk(dout, rwd);
    chk(32'(rdw), 32'h0);
    chk(32'(saw_ack), 32'h0);
    saw_as = 0;
    rq(0, 1, 0, 0, 4'h1);
    chk(lat, 2);
    chk(32'(saw_as), 32'h0);
    chk(adr, ra);
    chk(32'(fco), 32'(fc));
    axw(ebsc_pkg::ADDR_CTRL, 32'h0);
    rq(0, 0, 0, 0, 4'h1);
    chk(lat, lat0 + 1);
    axw(ebsc_pkg::ADDR_CTRL, 32'h9);
    brq_n <= 0;
    saw_gnt = 0;
    repeat (20) @(posedge clk);
    chk(32'(saw_gnt), 32'h0);
    saw_as = 0;
    rq(0, 1, 0, 0, 4'h1);
    chk(32'(saw_as & saw_ack), 32'h1);
    brq_n <= 1;
    axw(ebsc_pkg::ADDR_CTRL, 32'ha);
    brq_n <= 0;
    repeat (8) @(posedge clk);
    chk(32'(gnt_n), 32'h0);
    fork
      rq(0, 1, 0, 0, 4'h1);
      begin
        repeat (10) @(posedge clk);
        brq_n <= 1;
      end
    join
    chk(32'(lat > 10), 32'h1);
    axw(ebsc_pkg::ADDR_CTRL, 32'h8);
    brq_n <= 0;
    repeat (8) @(posedge clk);
    chk(32'(gnt_n), 32'h0);
    chk(32'(coe), 32'h0);
    brq_n <= 1;
    repeat (8) @(posedge clk);
    axw(ebsc_pkg::ADDR_CTRL, 32'hc);
    saw_as = 0;
    rq(1, 1, 0, 1, 4'h1);
    chk(32'(lbe), 32'h1);
    chk(32'(saw_as), 32'h0);
    rq(1, 1, 0, 1, ebsc_pkg::FC_SUPER_DATA);
    chk(32'(lbe), 32'h0);
    slv <= 1;
    repeat (6) @(posedge clk);
    axw(ebsc_pkg::ADDR_CTRL, 32'hb);
    axr(ebsc_pkg::ADDR_CTRL);
    chk(32'(q_rd[1:0]), 32'h0);
    print_verdict;
  end
endmodule
`default_nettype wire
